// >>> art_timer_map.svh
// register offsets, field positions, reset values and divider counts of the timer
`ifndef ART_TIMER_MAP_SVH
`define ART_TIMER_MAP_SVH

`define ART_OFS_CTRL       8'h00
`define ART_OFS_CNT_LOW    8'h04
`define ART_OFS_CNT_HIGH   8'h08
`define ART_OFS_RLD_LOW    8'h0c
`define ART_OFS_RLD_HIGH   8'h10
`define ART_OFS_CLK_CTRL   8'h14
`define ART_OFS_STATUS     8'h18

`define ART_CTRL_HIGH_FLAG 7
`define ART_CTRL_LOW_FLAG  6
`define ART_CTRL_LOW_IRQEN 5
`define ART_CTRL_CAPT_EN   4
`define ART_CTRL_SPLIT     3
`define ART_CTRL_RUN       2
`define ART_CTRL_EXT_SEL   0

`define ART_CLK_LOW_SEL    0
`define ART_CLK_HIGH_SEL   1
`define ART_CLK_IRQ_EN     2

`define ART_STAT_SYNC      0
`define ART_STAT_SUSPEND   1

`define ART_RESET_BYTE     8'h00
`define ART_DIV_SYS        4'hc
`define ART_DIV_EXT        3'h7
`define ART_SYNC_TICKS     2'h3

`endif

// >>> art_timer_pkg.sv
// types shared by the timer modules
package art_timer_pkg;
    typedef enum logic [1:0] {
        ART_RUN  = 2'b00,
        ART_SUSP = 2'b01,
        ART_SYNC = 2'b11
    } art_state_e;

    typedef logic [7:0] art_byte_t;
endpackage

// >>> art_tick_if.sv
// tick strobes from the clock source generator to the counter
interface art_tick_if;
    logic div12Tick;
    logic extTickSync;
    logic extTickDirect;

    modport source (output div12Tick, output extTickSync, output extTickDirect);
    modport sink   (input div12Tick, input extTickSync, input extTickDirect);
endinterface

// >>> art_tick_gen.sv
// prescalers: system clock / 12 and external pin / 8, with pin synchroniser
`include "art_timer_map.svh"
module art_tick_gen
    import art_timer_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic extClkPin,
    art_tick_if.source tick
);
    typedef struct packed {
        logic [3:0] div12Cnt;
        logic       pinMeta;
        logic       pinSync;
        logic       pinLast;
        logic [2:0] div8Cnt;
        logic       div12Tick;
        logic       extDirect;
        logic       extSync;
    } art_gen_s;

    art_gen_s gen_r;
    art_gen_s gen_nxt;

    // next state of both dividers
    always_comb begin
        gen_nxt           = gen_r;
        gen_nxt.pinMeta   = extClkPin;
        gen_nxt.pinSync   = gen_r.pinMeta;
        gen_nxt.pinLast   = gen_r.pinSync;
        gen_nxt.div12Tick = 1'b0;
        gen_nxt.extDirect = 1'b0;
        if (gen_r.div12Cnt == `ART_DIV_SYS - 4'h1) begin
            gen_nxt.div12Cnt  = 4'h0;
            gen_nxt.div12Tick = 1'b1;
        end else begin
            gen_nxt.div12Cnt = gen_r.div12Cnt + 4'h1;
        end
        // only the second stage is watched for edges
        if (gen_r.pinSync && !gen_r.pinLast) begin
            gen_nxt.div8Cnt = gen_r.div8Cnt + 3'h1;
            if (gen_r.div8Cnt == `ART_DIV_EXT) begin
                gen_nxt.extDirect = 1'b1;
            end
        end
        gen_nxt.extSync = gen_r.extDirect;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gen_r <= '0;
        end else begin
            gen_r <= gen_nxt;
        end
    end

    assign tick.div12Tick     = gen_r.div12Tick;
    assign tick.extTickSync   = gen_r.extSync;
    assign tick.extTickDirect = gen_r.extDirect;
endmodule

// >>> art_timer.sv
// auto-reload timer with split mode, comparator capture and suspend wake-up
`include "art_timer_map.svh"
module art_timer
    import art_timer_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        extClkPin,
    input  wire logic        cmpOut,
    input  wire logic        suspendMode,
    input  wire logic        otherWake,
    output logic             wakeUp,
    output logic             timerIrq
);
    // all state of the timer except the prescalers in one record, registered once below
    typedef struct packed {
        art_state_e state;
        logic [1:0] syncTicks;
        art_byte_t  cntLow;
        art_byte_t  cntHigh;
        art_byte_t  rldLow;
        art_byte_t  rldHigh;
        logic       highFlag;
        logic       lowFlag;
        logic       lowIrqEn;
        logic       captEn;
        logic       split;
        logic       run;
        logic       extSel;
        logic       lowClkSel;
        logic       highClkSel;
        logic       irqEn;
        logic       cmpMeta;
        logic       cmpSync;
        logic       cmpLast;
        logic       susMeta;
        logic       susSync;
        logic       susLast;
        logic       wakeMeta;
        logic       wakeSync;
        logic       wakeLast;
        logic       wake;
        logic       refuse;
        logic [31:0] rdata;
    } art_state_s;

    art_state_s st_r;
    art_state_s st_nxt;
    // tick strobes from the prescalers
    art_tick_if tickBus ();

    art_tick_gen u_tick_gen (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .extClkPin (extClkPin),
        .tick      (tickBus)
    );

    // pick the tick for one half from its select bit and the shared select
    function automatic logic half_tick(input logic sysSel, input logic extSel,
                                       input logic capt, input logic suspended,
                                       input logic d12, input logic eSync,
                                       input logic eDirect);
        logic t;
        t = 1'b0;
        if (sysSel) begin
            t = 1'b1;
        end else if (extSel && !capt) begin
            t = suspended ? eDirect : eSync;
        end else begin
            // capture ignores the external source and runs from /12 when the half's system select is clear
            t = d12;
        end
        return t;
    endfunction

    // counter byte address decode, used to refuse counter access while syncing
    function automatic logic is_count_reg(input logic [7:0] a);
        return (a == `ART_OFS_CNT_LOW) || (a == `ART_OFS_CNT_HIGH);
    endfunction

    // decoded views of the state, shared by the bus and the counter
    logic        suspended;
    logic        syncBusy;
    logic        setupRd;
    logic        wrAcc;
    logic        refused;
    logic        tickLow;
    logic        tickHigh;
    logic        captMode;
    logic        captEdge;
    logic        otherWakeEdge;
    logic [15:0] cnt16;
    logic [7:0]  ctrlRd;

    // capture needs enable and unsplit mode
    assign captMode  = st_r.captEn && !st_r.split;
    assign suspended = st_r.susSync;
    assign syncBusy  = (st_r.state == ART_SYNC);
    assign cnt16     = {st_r.cntHigh, st_r.cntLow};
    // edge seen from two synchronised samples
    assign captEdge  = st_r.cmpSync && !st_r.cmpLast;
    // a foreign wake may arrive as a level; only its rise matters
    assign otherWakeEdge = st_r.wakeSync && !st_r.wakeLast;
    assign tickLow  = half_tick(st_r.lowClkSel, st_r.extSel, captMode, suspended,
                                tickBus.div12Tick, tickBus.extTickSync,
                                tickBus.extTickDirect);
    // unused in 16-bit mode, where the low-half select drives the count
    assign tickHigh = half_tick(st_r.highClkSel, st_r.extSel, captMode, suspended,
                                tickBus.div12Tick, tickBus.extTickSync,
                                tickBus.extTickDirect);

    // counter bytes refused while the sync flag is up
    assign refused = syncBusy && is_count_reg(paddr);
    assign setupRd = psel && !penable && !pwrite;
    assign wrAcc   = psel && penable && pwrite && !st_r.refuse;
    assign ctrlRd  = {st_r.highFlag, st_r.lowFlag, st_r.lowIrqEn, st_r.captEn,
                      st_r.split, st_r.run, 1'b0, st_r.extSel};

    // zero wait states; read data captured in the setup cycle
    // so prdata comes from a flop; a value that moves during the
    // access cycle is therefore seen one read later
    // a refused counter access answers with an error, never a wait
    assign pready  = 1'b1;
    assign pslverr = psel && penable && st_r.refuse;
    assign prdata  = st_r.rdata;
    assign wakeUp  = st_r.wake;

    // timer irq follows the high flag while irqEn in clock control is set
    // low flag joins when its enable is set
    // either half may raise it in split mode
    // level output: it stays up until software clears the flag or its enable
    assign timerIrq = st_r.irqEn &&
                      (st_r.highFlag || (st_r.lowIrqEn && st_r.lowFlag));

    // whole next state: bus, counting, capture, suspend sequencing
    always_comb begin
        // overflow and capture events of this cycle
        logic setHigh;
        logic setLow;
        logic lowWrap;
        logic highWrap;
        st_nxt = st_r;
        setHigh  = 1'b0;
        setLow   = 1'b0;
        lowWrap  = 1'b0;
        highWrap = 1'b0;
        // pulses drop; pins shift through three flops, the first is never read
        st_nxt.wake     = 1'b0;
        st_nxt.cmpMeta  = cmpOut;
        st_nxt.cmpSync  = st_r.cmpMeta;
        st_nxt.cmpLast  = st_r.cmpSync;
        st_nxt.susMeta  = suspendMode;
        st_nxt.susSync  = st_r.susMeta;
        st_nxt.susLast  = st_r.susSync;
        st_nxt.wakeMeta = otherWake;
        st_nxt.wakeSync = st_r.wakeMeta;
        st_nxt.wakeLast = st_r.wakeSync;

        // bus reads, answered in the following access cycle
        if (setupRd) begin
            case (paddr)
                `ART_OFS_CTRL:     st_nxt.rdata = {24'h000000, ctrlRd};
                `ART_OFS_CNT_LOW:  st_nxt.rdata = {24'h000000, st_r.cntLow};
                `ART_OFS_CNT_HIGH: st_nxt.rdata = {24'h000000, st_r.cntHigh};
                `ART_OFS_RLD_LOW:  st_nxt.rdata = {24'h000000, st_r.rldLow};
                `ART_OFS_RLD_HIGH: st_nxt.rdata = {24'h000000, st_r.rldHigh};
                `ART_OFS_CLK_CTRL: st_nxt.rdata = {29'h00000000, st_r.irqEn,
                                                   st_r.highClkSel, st_r.lowClkSel};
                `ART_OFS_STATUS:   st_nxt.rdata = {30'h00000000, suspended, syncBusy};
                // unmapped offsets read zero
                default:           st_nxt.rdata = 32'h00000000;
            endcase
            if (refused) begin
                st_nxt.rdata = 32'h00000000;
            end
        end

        // refusal latched at setup, so error, data and write agree
        if (psel && !penable) begin
            st_nxt.refuse = refused;
        end

        // bus writes; hardware updates below override on a collision
        if (wrAcc) begin
            case (paddr)
                `ART_OFS_CTRL: begin
                    st_nxt.highFlag = pwdata[`ART_CTRL_HIGH_FLAG];
                    st_nxt.lowFlag  = pwdata[`ART_CTRL_LOW_FLAG];
                    st_nxt.lowIrqEn = pwdata[`ART_CTRL_LOW_IRQEN];
                    st_nxt.captEn   = pwdata[`ART_CTRL_CAPT_EN];
                    st_nxt.split    = pwdata[`ART_CTRL_SPLIT];
                    st_nxt.run      = pwdata[`ART_CTRL_RUN];
                    st_nxt.extSel   = pwdata[`ART_CTRL_EXT_SEL];
                end
                `ART_OFS_CNT_LOW:  st_nxt.cntLow  = pwdata[7:0];
                `ART_OFS_CNT_HIGH: st_nxt.cntHigh = pwdata[7:0];
                `ART_OFS_RLD_LOW:  st_nxt.rldLow  = pwdata[7:0];
                `ART_OFS_RLD_HIGH: st_nxt.rldHigh = pwdata[7:0];
                `ART_OFS_CLK_CTRL: begin
                    st_nxt.lowClkSel  = pwdata[`ART_CLK_LOW_SEL];
                    st_nxt.highClkSel = pwdata[`ART_CLK_HIGH_SEL];
                    st_nxt.irqEn      = pwdata[`ART_CLK_IRQ_EN];
                end
                default: ;
            endcase
        end

        if (st_r.split) begin
            // low half reloads from its own byte
            if (tickLow) begin
                if (st_r.cntLow == 8'hff) begin
                    st_nxt.cntLow = st_r.rldLow;
                    lowWrap = 1'b1;
                end else begin
                    st_nxt.cntLow = st_r.cntLow + 8'h01;
                end
            end
            if (tickHigh && st_r.run) begin
                if (st_r.cntHigh == 8'hff) begin
                    st_nxt.cntHigh = st_r.rldHigh;
                    highWrap = 1'b1;
                end else begin
                    st_nxt.cntHigh = st_r.cntHigh + 8'h01;
                end
            end
            setLow  = lowWrap;
            setHigh = highWrap;
        end else if (st_r.run && tickLow) begin
            {st_nxt.cntHigh, st_nxt.cntLow} = cnt16 + 16'h0001;
            // the low flag follows the low byte in every mode
            setLow = (st_r.cntLow == 8'hff);
            if (cnt16 == 16'hffff) begin
                setHigh = 1'b1;
                // capture mode wraps to zero: the reload pair holds captures
                if (!captMode) begin
                    st_nxt.cntLow  = st_r.rldLow;
                    st_nxt.cntHigh = st_r.rldHigh;
                end
            end
        end

        // capture copies the live count into the reload pair
        // a comparator rise in split mode is dropped by the mode gate
        if (captMode && captEdge) begin
            st_nxt.rldLow  = st_r.cntLow;
            st_nxt.rldHigh = st_r.cntHigh;
            setHigh = 1'b1;
        end

        // hardware only sets; set beats a same-cycle clear
        if (setHigh) begin
            st_nxt.highFlag = 1'b1;
        end
        if (setLow) begin
            st_nxt.lowFlag = 1'b1;
        end

        // suspend and wake sequencing
        case (st_r.state)
            ART_RUN: begin
                // only a fresh suspend; the input lingers high after a timer wake
                if (suspended && !st_r.susLast) begin
                    st_nxt.state = ART_SUSP;
                end
            end
            ART_SUSP: begin
                // overflow in suspend wakes the device
                // in split mode either half may wake it
                if (setHigh || setLow && st_r.split) begin
                    st_nxt.wake  = 1'b1;
                    st_nxt.state = ART_RUN;
                end else if (otherWakeEdge || !suspended) begin
                    // foreign wake needs three timer ticks to settle
                    st_nxt.state     = ART_SYNC;
                    st_nxt.syncTicks = 2'h0;
                end
            end
            ART_SYNC: begin
                // counts low-half ticks; a stopped low clock holds the flag up
                if (tickLow) begin
                    if (st_r.syncTicks == `ART_SYNC_TICKS - 2'h1) begin
                        st_nxt.state = ART_RUN;
                    end else begin
                        st_nxt.syncTicks = st_r.syncTicks + 2'h1;
                    end
                end
            end
            default: st_nxt.state = ART_RUN;
        endcase
    end

    // one register for the whole state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r       <= '0;
            st_r.state <= ART_RUN;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// >>> art_timer_props.sv
// checker on the timer ports: bus answers, interrupt and wake behaviour
module art_timer_props
    import art_timer_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        extClkPin,
    input wire logic        cmpOut,
    input wire logic        suspendMode,
    input wire logic        otherWake,
    input wire logic        wakeUp,
    input wire logic        timerIrq
);
    logic [2:0] clkSh_r;
    wire        rdAcc = psel && penable && !pwrite;
    wire        wrAcc = psel && penable && pwrite;

    // shadow of clock control, which hardware never alters
    always_ff @(posedge ref_clk) begin
        if (reset)
            clkSh_r <= 3'h0;
        else if (wrAcc && paddr == 8'h14)
            clkSh_r <= pwdata[2:0];
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // bus answers tied to address and refusal
    a_upper_zero: assert property (rdAcc |-> prdata[31:8] == 24'h0)
        else $error("read data above low byte not zero");
    a_unmapped_zero: assert property (rdAcc && (paddr[1:0] != 2'h0 || paddr > 8'h18)
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_err_only_count: assert property (pslverr |->
        psel && penable && (paddr == 8'h04 || paddr == 8'h08)) else $error("stray error");
    a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_clk_readback: assert property (rdAcc && paddr == 8'h14 |-> prdata[2:0] == clkSh_r)
        else $error("clock select readback wrong");

    // interrupt follows enable and flags; flags leave only by software
    a_irq_needs_en: assert property (timerIrq |-> clkSh_r[2])
        else $error("interrupt while disabled");
    a_irq_from_flags: assert property (rdAcc && paddr == 8'h00 |->
        $past(timerIrq) == ($past(clkSh_r[2]) && (prdata[7] || prdata[5] && prdata[6])))
        else $error("interrupt does not match flags");
    a_flag_no_clear: assert property ($fell(timerIrq) |->
        $past(wrAcc && (paddr == 8'h00 || paddr == 8'h14))) else $error("flag self cleared");
    a_no_wake_awake: assert property (!suspendMode [*6] |=> !wakeUp)
        else $error("wake pulse while awake");

    cover property (pslverr);
    cover property (wakeUp);
    cover property ($fell(timerIrq));
endmodule

bind art_timer art_timer_props art_timer_props_inst (.ref_clk, .reset, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .extClkPin, .cmpOut,
    .suspendMode, .otherWake, .wakeUp, .timerIrq);

// >>> art_timer_tb.sv
// self-checking bench for the auto-reload timer over its register bus
module art_timer_tb
    import art_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

`define CHK(nm, ex, ac) begin samples_checked++; if ((ac) !== (ex)) begin n_fail++; \
    $display("unexpected %s: expected %h, seen %h", nm, ex, ac); end end

    logic        ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, extClkPin = 1'b0, cmpOut = 1'b0;
    logic        suspendMode = 1'b0, otherWake = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, wakeUp, timerIrq, er;
    logic        seen = 1'b0;
    logic [7:0]  rd;
    int          n_fail = 0;
    int          samples_checked = 0;

    art_timer art_timer_inst (.ref_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .extClkPin, .cmpOut, .suspendMode, .otherWake,
        .wakeUp, .timerIrq);

    // 50 MHz system clock
    always #10 ref_clk = ~ref_clk;

    // one transfer; an idle cycle follows so no signal is driven twice in a step
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int   i;
        logic rdy;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // the answer is taken at the rising edge that samples pready high
        do begin
            @(posedge ref_clk);
            rdy = pready;
            rd = prdata[7:0];
            er = pslverr;
            i++;
        end while (rdy !== 1'b1 && i < 40);
        if (rdy !== 1'b1) begin
            n_fail++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] ex);
        bus(1'b0, a, 8'h00);
        `CHK($sformatf("reg %h", a), ex, rd)
    endtask

    // bounded poll of one register bit
    task automatic waitBit(input logic [7:0] a, input int b, input logic v);
        int i;
        i = 0;
        do begin
            bus(1'b0, a, 8'h00);
            i++;
        end while (rd[b] !== v && i < 60);
        `CHK("polled bit", v, rd[b])
    endtask

    task automatic conclude();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a <= 'h1c; a += 4) rdChk(8'(a), 8'h00);
        bus(1'b1, 8'h04, 8'hfe);
        bus(1'b1, 8'h08, 8'hff);
        bus(1'b1, 8'h0c, 8'hcd);
        bus(1'b1, 8'h10, 8'hab);
        rdChk(8'h04, 8'hfe);
        rdChk(8'h0c, 8'hcd);
        // 16-bit overflow from system clock
        bus(1'b1, 8'h14, 8'h05);
        bus(1'b1, 8'h00, 8'h04);
        waitBit(8'h00, 7, 1'b1);
        `CHK("ctrl", 8'hc4, rd)
        `CHK("irq", 1'b1, timerIrq)
        bus(1'b1, 8'h00, 8'h00);
        rdChk(8'h08, 8'hab);
        `CHK("irq off", 1'b0, timerIrq)
        // split: low half free running, high half gated
        bus(1'b1, 8'h0c, 8'hf0);
        bus(1'b1, 8'h10, 8'h80);
        bus(1'b1, 8'h14, 8'h07);
        bus(1'b1, 8'h00, 8'h28);
        waitBit(8'h00, 6, 1'b1);
        `CHK("split ctrl", 8'h68, rd)
        `CHK("low irq", 1'b1, timerIrq)
        rdChk(8'h08, 8'hab);
        bus(1'b0, 8'h04, 8'h00);
        `CHK("low reload", 4'hf, rd[7:4])
        bus(1'b1, 8'h00, 8'h08);
        waitBit(8'h00, 6, 1'b1);
        `CHK("masked irq", 1'b0, timerIrq)
        bus(1'b1, 8'h08, 8'hfe);
        bus(1'b1, 8'h00, 8'h0c);
        waitBit(8'h00, 7, 1'b1);
        `CHK("high irq", 1'b1, timerIrq)
        bus(1'b0, 8'h08, 8'h00);
        `CHK("high reload", 1'b1, rd[7])
        // capture of the count on a comparator rise
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b1, 8'h08, 8'h00);
        bus(1'b1, 8'h04, 8'h00);
        bus(1'b1, 8'h00, 8'h14);
        // counter on the system clock, far faster than the comparator
        cmpOut <= 1'b1;
        waitBit(8'h00, 7, 1'b1);
        rdChk(8'h10, 8'h00);
        bus(1'b0, 8'h0c, 8'h00);
        // count starts one edge after run lands; two sync flops and the edge add three
        `CHK("captured", 8'h03, rd)
        // suspend on external ticks until overflow wakes
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b1, 8'h14, 8'h00);
        bus(1'b1, 8'h04, 8'hfd);
        bus(1'b1, 8'h08, 8'hff);
        bus(1'b1, 8'h00, 8'h05);
        cmpOut <= 1'b0;
        suspendMode <= 1'b1;
        for (int i = 0; i < 400 && seen !== 1'b1; i++) begin
            extClkPin <= ~extClkPin;
            @(negedge ref_clk);
            seen = wakeUp;
            @(posedge ref_clk);
        end
        `CHK("wake", 1'b1, seen)
        suspendMode <= 1'b0;
        // other wake source: counter locked while resynchronising
        bus(1'b1, 8'h00, 8'h04);
        suspendMode <= 1'b1;
        repeat (4) @(posedge ref_clk);
        otherWake <= 1'b1;
        suspendMode <= 1'b0;
        waitBit(8'h18, 0, 1'b1);
        bus(1'b0, 8'h04, 8'h00);
        `CHK("refused", 1'b1, er)
        `CHK("refused data", 8'h00, rd)
        bus(1'b1, 8'h04, 8'h55);
        `CHK("refused write", 1'b1, er)
        waitBit(8'h18, 0, 1'b0);
        bus(1'b0, 8'h04, 8'h00);
        `CHK("released", 1'b0, er)
        `CHK("write dropped", 1'b1, rd < 8'h40)
        conclude();
    end
endmodule
